// >>> esaom_pkg.sv
package esaom_pkg;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_BAUD = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam int CTRL_W = 14;
   localparam int BAUD_W = 16;
   localparam int STAT_LOST = 0;
   localparam int STAT_BA = 1;
   localparam int N_BA = 4;
   localparam logic [BAUD_W-1:0] BAUD_RST = 16'h0010;
   localparam logic [3:0] ESC_CHAR_BITS = 4'h9;
   localparam logic [3:0] ASY_LAST_BIT = 4'h7;
   localparam logic [3:0] TAIL_STOP = 4'h1;
   localparam logic [3:0] TAIL_PAR_STOP = 4'h2;
   localparam logic [2:0] OVERHEAD_SLOT_THIRTYTWO_B1 = 3'h0;
   localparam logic [2:0] OVERHEAD_SLOT_THIRTYTWO_B5 = 3'h4;
   localparam logic [2:0] OCTET_FIRST = 3'h0;

   typedef enum logic [1:0] {FRM_IDR, FRM_IBS, FRM_CNS} esaom_frm_t;
   typedef enum logic [1:0] {ESC_OFF, ESC_SYNC, ESC_ASYNC} esaom_esc_t;
   typedef enum logic [1:0] {IAUX_OFF, IAUX_64K, IAUX_32K_V1, IAUX_32K_V2} esaom_iaux_t;
   typedef enum logic [1:0] {BAUX_OFF, BAUX_LOW, BAUX_SYNC} esaom_baux_t;
   typedef enum logic [1:0] {KIND_ESC8K, KIND_V1, KIND_V2, KIND_OVH} esaom_kind_t;
   typedef enum logic [1:0] {OSLOT_16, OSLOT_32, OSLOT_48, OSLOT_OTHER} esaom_oslot_t;
   typedef enum logic [1:0] {AS_IDLE, AS_START, AS_DATA, AS_TAIL} esaom_as_t;

   // control word, frm in the lowest bits
   typedef struct packed {
      logic [N_BA-1:0] ba_sel;
      logic par8;
      logic route_mc;
      esaom_baux_t baux;
      esaom_iaux_t iaux;
      esaom_esc_t service_overhead_channel;
      esaom_frm_t frm;
   } esaom_ctrl_t;

   // one link bit opportunity
   typedef struct packed {
      logic stb;
      esaom_kind_t kind;
      esaom_oslot_t slot;
      logic [2:0] bitn;
   } esaom_lk_t;

   localparam esaom_ctrl_t CTRL_RST = '{ba_sel: 4'h0, par8: 1'b0, route_mc: 1'b0,
      baux: BAUX_OFF, iaux: IAUX_OFF, service_overhead_channel: ESC_OFF, frm: FRM_IDR};
endpackage

// >>> esaom_top.sv
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - service channel off in intermediate-rate framing sends all ones in its 8k slot.
// - sync service mode gives the port plain synchronous access to the 8k channel.
// - async service characters travel as nine bits, start plus eight data.
// - intermediate aux off keeps both voice slots as audio, aux port idle.
// - 64k aux replaces both voice slots with aux data.
// - 32k aux in voice slot one, slot two stays audio.
// - 32k aux in voice slot two, slot one stays audio.
// - business low-rate aux uses only overhead slot thirtytwo bit one, oversampled.
// - low-rate aux still gets a clock for synchronous use.
// - sync aux may take up to 21/32 of the overhead.
// - sync aux uses clock, data, octet lines, not the low-rate data line.
// - closed net with service gives all overhead to service channel, no aux.
// - async service port uses configurable character format and baud rate.
// - each of four backward alarms comes from an input or receive fault.
// - service channel can be routed to the internal monitor-and-control port.
// - maximum aux allocation is slots sixteen, thirtytwo bits 1,5-8, fortyeight.
// - standard service allocation is slots sixteen, thirtytwo bits 5-8, fortyeight.
module esaom_top (
   input wire logic hclk, // bus clock
   input wire logic hresetn, // async reset
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write
   input wire logic [2:0] hsize, // size, words only
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic [31:0] hrdata, // read data
   output logic hreadyout, // slave ready
   output logic hresp, // response
   input wire logic link_clk, // link clock
   input wire esaom_pkg::esaom_lk_t lk_i, // link bit opportunity
   input wire logic lk_rx_bit, // received bit of that opportunity
   output logic tx_bit, // bit to transmit
   output logic tx_vld, // tx_bit valid
   input wire logic audio_v1_bit, // codec voice one
   input wire logic audio_v2_bit, // codec voice two
   input wire logic mc_tx_bit, // m&c port line out
   output logic mc_rx_bit, // m&c port line in
   input wire logic esc_din, // service port data pin
   output logic esc_dout, // service port data out
   output logic esc_sclk, // service sync clock pulse
   input wire logic aux_din, // sync aux data pin
   output logic aux_dout, // aux data out
   output logic aux_sclk, // aux clock pulse
   output logic aux_octet, // aux octet marker
   input wire logic aux_lr_din, // low-rate aux data pin
   input wire logic [esaom_pkg::N_BA-1:0] ba_ext_in, // external alarm pins
   input wire logic rx_fault, // own receive fault
   output logic [esaom_pkg::N_BA-1:0] ba_tx // backward alarms
);
   // ---------------- bus side ----------------
   logic wr_q, cfg_tog_q, lost_q;
   logic [7:0] addr_q;
   logic [31:0] rdata_q, rdata_d;
   esaom_pkg::esaom_ctrl_t ctrl_q;
   logic [esaom_pkg::BAUD_W-1:0] baud_q;
   logic [esaom_pkg::N_BA-1:0] ba_s1_q, ba_s2_q, ba_q;
   logic [2:0] lost_h_q;
   logic lost_tog_q;

   wire logic acc = hsel & htrans[1] & hready;
   wire logic wr_ctrl = wr_q & (addr_q == esaom_pkg::ADDR_CTRL);
   wire logic wr_baud = wr_q & (addr_q == esaom_pkg::ADDR_BAUD);
   wire logic wr_stat = wr_q & (addr_q == esaom_pkg::ADDR_STAT);
   wire logic lost_ev = lost_h_q[2] ^ lost_h_q[1];
   wire logic lost_clr = wr_stat & hwdata[esaom_pkg::STAT_LOST];
   wire logic [31:0] stat_w = {27'h000_0000, ba_q, lost_q};

   always_comb begin
      case (haddr[7:0])
         esaom_pkg::ADDR_CTRL: rdata_d = {18'h0_0000, ctrl_q};
         esaom_pkg::ADDR_BAUD: rdata_d = {16'h0000, baud_q};
         esaom_pkg::ADDR_STAT: rdata_d = stat_w;
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   assign hrdata = rdata_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign ba_tx = ba_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         addr_q <= 8'h00;
         rdata_q <= 32'h0000_0000;
      end else begin
         wr_q <= acc & hwrite;
         addr_q <= haddr[7:0];
         if (acc & !hwrite) begin
            rdata_q <= rdata_d;
         end
      end
   end

   // config change is announced by a toggle; nothing holds the registers while the link copies them
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= esaom_pkg::CTRL_RST;
         baud_q <= esaom_pkg::BAUD_RST;
         cfg_tog_q <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= esaom_pkg::esaom_ctrl_t'(hwdata[esaom_pkg::CTRL_W-1:0]);
         end
         if (wr_baud) begin
            baud_q <= hwdata[esaom_pkg::BAUD_W-1:0];
         end
         if (wr_ctrl | wr_baud) begin
            cfg_tog_q <= ~cfg_tog_q;
         end
      end
   end

   // sticky lost flag: a new loss wins over a clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lost_h_q <= 3'h0;
         lost_q <= 1'b0;
      end else begin
         lost_h_q <= {lost_h_q[1:0], lost_tog_q};
         lost_q <= lost_ev | (lost_q & ~lost_clr);
      end
   end

   generate
      for (genvar i = 0; i < esaom_pkg::N_BA; i++) begin : g_ba
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               ba_s1_q[i] <= 1'b0;
               ba_s2_q[i] <= 1'b0;
               ba_q[i] <= 1'b0;
            end else begin
               ba_s1_q[i] <= ba_ext_in[i];
               ba_s2_q[i] <= ba_s1_q[i];
               ba_q[i] <= ctrl_q.ba_sel[i] ? rx_fault : ba_s2_q[i];
            end
         end
      end
   endgenerate

   // ---------------- link side ----------------
   logic [1:0] lrst_q;
   logic [2:0] ctog_q;
   esaom_pkg::esaom_ctrl_t lc_q;
   logic [esaom_pkg::BAUD_W-1:0] lbaud_q, cnt_q;
   logic [1:0] esc_s_q, aux_s_q, lr_s_q;
   esaom_pkg::esaom_as_t as_q;
   logic [3:0] nb_q, shn_q;
   logic [7:0] dat_q;
   logic [8:0] sh_q;
   logic [2:0] aoc_q;
   logic tx_bit_q, tx_vld_q, esc_sclk_q, esc_dout_q, mc_rx_q;
   logic aux_sclk_q, aux_octet_q, aux_dout_q;

   wire logic lrst_n = lrst_q[1];
   wire logic intermediate_rate_framing = lc_q.frm == esaom_pkg::FRM_IDR;
   wire logic business_service_framing = lc_q.frm == esaom_pkg::FRM_IBS;
   wire logic cns = lc_q.frm == esaom_pkg::FRM_CNS;
   wire logic ovh = lk_i.stb & (lk_i.kind == esaom_pkg::KIND_OVH);
   wire logic s16 = lk_i.slot == esaom_pkg::OSLOT_16;
   wire logic s32 = lk_i.slot == esaom_pkg::OSLOT_32;
   wire logic s48 = lk_i.slot == esaom_pkg::OSLOT_48;
   wire logic b1 = lk_i.bitn == esaom_pkg::OVERHEAD_SLOT_THIRTYTWO_B1;
   wire logic b58 = lk_i.bitn >= esaom_pkg::OVERHEAD_SLOT_THIRTYTWO_B5;
   wire logic in_std = s16 | s48 | (s32 & b58);
   wire logic in_max = in_std | (s32 & b1);
   wire logic kv1 = lk_i.stb & (lk_i.kind == esaom_pkg::KIND_V1);
   wire logic kv2 = lk_i.stb & (lk_i.kind == esaom_pkg::KIND_V2);
   wire logic a64 = lc_q.iaux == esaom_pkg::IAUX_64K;
   wire logic aux_v1 = kv1 & (a64 | lc_q.iaux == esaom_pkg::IAUX_32K_V1);
   wire logic aux_v2 = kv2 & (a64 | lc_q.iaux == esaom_pkg::IAUX_32K_V2);
   wire logic bsync = lc_q.baux == esaom_pkg::BAUX_SYNC;
   // sync aux takes the whole 21/32 share, leaving the service channel nothing
   wire logic aux_slot = (intermediate_rate_framing & (aux_v1 | aux_v2)) | (ovh & business_service_framing & bsync & in_max);
   wire logic lr_slot = ovh & business_service_framing & (lc_q.baux == esaom_pkg::BAUX_LOW) & s32 & b1;
   wire logic esc_8k = lk_i.stb & (lk_i.kind == esaom_pkg::KIND_ESC8K);
   wire logic esc_slot = (intermediate_rate_framing & esc_8k) | (ovh & business_service_framing & ~bsync & in_std) | (ovh & cns);
   wire logic voice = intermediate_rate_framing & (kv1 | kv2) & ~aux_slot;
   wire logic esc_asy = lc_q.service_overhead_channel == esaom_pkg::ESC_ASYNC;
   wire logic esc_syn = lc_q.service_overhead_channel == esaom_pkg::ESC_SYNC;
   wire logic esc_src = lc_q.route_mc ? mc_tx_bit : esc_s_q[1];
   wire logic asy_line = esc_asy & esc_src;
   wire logic asy_bit = (shn_q != 4'h0) ? sh_q[0] : 1'b1;
   wire logic esc_bit = esc_syn ? esc_src : (esc_asy ? asy_bit : 1'b1);
   wire logic voice_bit = kv1 ? audio_v1_bit : audio_v2_bit;
   wire logic tx_d = aux_slot ? aux_s_q[1] : (lr_slot ? lr_s_q[1] :
      (esc_slot ? esc_bit : (voice ? voice_bit : 1'b1)));
   wire logic cnt_z = cnt_q == '0;
   wire logic asy_done = (as_q == esaom_pkg::AS_DATA) & cnt_z & (nb_q == esaom_pkg::ASY_LAST_BIT);
   wire logic [7:0] dat_d = {asy_line, dat_q[7:1]};
   wire logic sh_load = asy_done & (shn_q == 4'h0);
   wire logic sh_shift = esc_slot & esc_asy & (shn_q != 4'h0);

   assign tx_bit = tx_bit_q;
   assign tx_vld = tx_vld_q;
   assign esc_sclk = esc_sclk_q;
   assign esc_dout = esc_dout_q;
   assign mc_rx_bit = mc_rx_q;
   assign aux_sclk = aux_sclk_q;
   assign aux_octet = aux_octet_q;
   assign aux_dout = aux_dout_q;

   always_ff @(posedge link_clk or negedge hresetn) begin
      if (!hresetn) begin
         lrst_q <= 2'h0;
      end else begin
         lrst_q <= {lrst_q[0], 1'b1};
      end
   end

   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         ctog_q <= 3'h0;
         lc_q <= esaom_pkg::CTRL_RST;
         lbaud_q <= esaom_pkg::BAUD_RST;
         esc_s_q <= 2'h3;
         aux_s_q <= 2'h3;
         lr_s_q <= 2'h3;
      end else begin
         ctog_q <= {ctog_q[1:0], cfg_tog_q};
         esc_s_q <= {esc_s_q[0], esc_din};
         aux_s_q <= {aux_s_q[0], aux_din};
         lr_s_q <= {lr_s_q[0], aux_lr_din};
         if (ctog_q[2] ^ ctog_q[1]) begin
            lc_q <= ctrl_q;
            lbaud_q <= baud_q;
         end
      end
   end

   // async receiver on the service port; stop and parity bits are only waited out
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         as_q <= esaom_pkg::AS_IDLE;
         cnt_q <= '0;
         nb_q <= 4'h0;
         dat_q <= 8'h00;
      end else begin
         cnt_q <= cnt_z ? lbaud_q : cnt_q - 1'b1;
         case (as_q)
            esaom_pkg::AS_IDLE: begin
               if (esc_asy & !asy_line) begin
                  as_q <= esaom_pkg::AS_START;
                  cnt_q <= lbaud_q >> 1;
               end
            end
            esaom_pkg::AS_START: begin
               if (cnt_z) begin
                  as_q <= asy_line ? esaom_pkg::AS_IDLE : esaom_pkg::AS_DATA;
                  nb_q <= 4'h0;
               end
            end
            esaom_pkg::AS_DATA: begin
               if (cnt_z) begin
                  dat_q <= dat_d;
                  nb_q <= nb_q + 4'h1;
                  if (asy_done) begin
                     as_q <= esaom_pkg::AS_TAIL;
                     nb_q <= lc_q.par8 ? esaom_pkg::TAIL_PAR_STOP : esaom_pkg::TAIL_STOP;
                  end
               end
            end
            esaom_pkg::AS_TAIL: begin
               if (cnt_z) begin
                  nb_q <= nb_q - 4'h1;
                  if (nb_q == esaom_pkg::TAIL_STOP) begin
                     as_q <= esaom_pkg::AS_IDLE;
                  end
               end
            end
            default: as_q <= esaom_pkg::AS_IDLE;
         endcase
      end
   end

   // one character in flight; a second arriving early is dropped and reported
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         sh_q <= 9'h1ff;
         shn_q <= 4'h0;
         lost_tog_q <= 1'b0;
      end else begin
         if (sh_load) begin
            sh_q <= {dat_d, 1'b0};
            shn_q <= esaom_pkg::ESC_CHAR_BITS;
         end else if (sh_shift) begin
            sh_q <= {1'b1, sh_q[8:1]};
            shn_q <= shn_q - 4'h1;
         end
         if (asy_done & !sh_load) begin
            lost_tog_q <= ~lost_tog_q;
         end
      end
   end

   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         tx_bit_q <= 1'b1;
         tx_vld_q <= 1'b0;
         esc_sclk_q <= 1'b0;
         esc_dout_q <= 1'b1;
         mc_rx_q <= 1'b1;
         aux_sclk_q <= 1'b0;
         aux_octet_q <= 1'b0;
         aux_dout_q <= 1'b1;
         aoc_q <= 3'h0;
      end else begin
         tx_bit_q <= tx_d;
         tx_vld_q <= lk_i.stb;
         esc_sclk_q <= esc_slot & esc_syn & !lc_q.route_mc;
         aux_sclk_q <= aux_slot | lr_slot;
         aux_octet_q <= aux_slot & (aoc_q == esaom_pkg::OCTET_FIRST);
         if (aux_slot) begin
            aoc_q <= aoc_q + 3'h1;
         end
         if (aux_slot | lr_slot) begin
            aux_dout_q <= lk_rx_bit;
         end
         if (esc_slot & lc_q.service_overhead_channel != esaom_pkg::ESC_OFF) begin
            if (lc_q.route_mc) begin
               mc_rx_q <= lk_rx_bit;
            end else begin
               esc_dout_q <= lk_rx_bit;
            end
         end
      end
   end

   // ---------------- checks ----------------
   AST_ESC_OFF_ONES: assert property (@(posedge link_clk) disable iff (!lrst_n)
      intermediate_rate_framing & esc_8k & lc_q.service_overhead_channel == esaom_pkg::ESC_OFF |=> tx_vld & tx_bit)
      else $error("service slot not all ones while off");
   AST_SYNC_ACCESS: assert property (@(posedge link_clk) disable iff (!lrst_n)
      intermediate_rate_framing & esc_8k & esc_syn & !lc_q.route_mc |=> esc_sclk & tx_bit == $past(esc_s_q[1]))
      else $error("sync service bit not passed with clock");
   AST_CHAR_NINE: assert property (@(posedge link_clk) disable iff (!lrst_n)
      sh_load |=> shn_q == esaom_pkg::ESC_CHAR_BITS & !sh_q[0])
      else $error("async character not framed as nine bits");
   AST_AUX_OFF: assert property (@(posedge link_clk) disable iff (!lrst_n)
      intermediate_rate_framing & (kv1 | kv2) & lc_q.iaux == esaom_pkg::IAUX_OFF
      |=> !aux_sclk & tx_bit == $past(voice_bit))
      else $error("voice slot not audio with aux off");
   AST_AUX_64K: assert property (@(posedge link_clk) disable iff (!lrst_n)
      intermediate_rate_framing & (kv1 | kv2) & a64 |=> aux_sclk & tx_bit == $past(aux_s_q[1]))
      else $error("64k aux not in voice slot");
   AST_AUX_V1: assert property (@(posedge link_clk) disable iff (!lrst_n)
      intermediate_rate_framing & kv2 & lc_q.iaux == esaom_pkg::IAUX_32K_V1
      |=> !aux_sclk & tx_bit == $past(audio_v2_bit))
      else $error("voice slot two lost audio");
   AST_AUX_V2: assert property (@(posedge link_clk) disable iff (!lrst_n)
      intermediate_rate_framing & kv1 & lc_q.iaux == esaom_pkg::IAUX_32K_V2
      |=> !aux_sclk & tx_bit == $past(audio_v1_bit))
      else $error("voice slot one lost audio");
   AST_LOW_RATE_ONLY: assert property (@(posedge link_clk) disable iff (!lrst_n)
      ovh & business_service_framing & lc_q.baux == esaom_pkg::BAUX_LOW & !(s32 & b1) |=> !aux_sclk)
      else $error("low-rate aux used a slot beyond bit one");
   AST_CNS_NO_AUX: assert property (@(posedge link_clk) disable iff (!lrst_n)
      ovh & cns |=> !aux_sclk ##0 tx_bit == $past(esc_bit))
      else $error("closed net overhead not given to service channel");
   AST_BA_SOURCE: assert property (@(posedge hclk) disable iff (!hresetn)
      ctrl_q.ba_sel[0] ##1 ctrl_q.ba_sel[0] |-> ba_tx[0] == $past(rx_fault))
      else $error("alarm not taken from receive fault");
   COV_ASYNC_CHAR: cover property (@(posedge link_clk) disable iff (!lrst_n) sh_load);
   COV_CHAR_LOST: cover property (@(posedge link_clk) disable iff (!lrst_n) asy_done & !sh_load);
   COV_SYNC_OCTET: cover property (@(posedge link_clk) disable iff (!lrst_n) aux_octet & bsync);
endmodule // esaom_top
`default_nettype wire

// >>> esaom_term_model.sv
`timescale 1ns/10ps
`default_nettype none
module esaom_term_model (
   input wire logic link_clk, // link clock supplied by the device
   input wire logic sync_lvl, // level offered on the sync service line
   input wire logic aux_lvl, // level offered on the sync aux line
   input wire logic lr_lvl, // level offered on the low-rate aux line
   output logic esc_din, // service port data pin
   output logic aux_din, // sync aux data pin
   output logic aux_lr_din // low-rate aux data pin
);
   logic busy = 1'b0;
   logic ser = 1'b1;

   initial begin
      esc_din = 1'b1;
      aux_din = 1'b0;
      aux_lr_din = 1'b1;
   end

   // data only moves on the device's own clock edges
   always @(posedge link_clk) begin
      esc_din <= busy ? ser : sync_lvl;
      aux_din <= aux_lvl;
      aux_lr_din <= lr_lvl;
   end

   // one 8N1 character; cyc link cycles per bit, nothing paces the source to the channel rate
   task automatic send_char(input logic [7:0] ch, input int cyc);
      logic [9:0] fr;
      fr = {1'b1, ch, 1'b0};
      busy <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         ser <= fr[i];
         repeat (cyc) @(posedge link_clk);
      end
      busy <= 1'b0;
   endtask
endmodule // esaom_term_model
`default_nettype wire

// >>> esaom_aux_overhead_mux_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fails++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module esc_aux_overhead_mux_bench;
   logic hclk, hresetn, hsel, hwrite, hready, hresp, hreadyout, link_clk, lk_rx_bit;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   esaom_pkg::esaom_lk_t lk_i;
   esaom_pkg::esaom_ctrl_t c;
   logic tx_bit, tx_vld, audio_v1_bit, audio_v2_bit, mc_tx_bit, mc_rx_bit, esc_din, esc_dout;
   logic esc_sclk, aux_din, aux_dout, aux_sclk, aux_octet, aux_lr_din, rx_fault;
   logic sync_lvl, aux_lvl, lr_lvl, v1a, v2a;
   logic [3:0] ba_ext_in, ba_tx;
   logic [1:0] sl [7] = '{0, 1, 1, 1, 1, 2, 3};
   logic [2:0] bn [7] = '{0, 0, 1, 4, 7, 3, 0};
   int fails = 0, total_checks = 0, cyc = 0, o;
   logic s32b1, sstd;

   assign hready = hreadyout;
   esaom_top esaom_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link_clk(link_clk), .lk_i(lk_i),
      .lk_rx_bit(lk_rx_bit), .tx_bit(tx_bit), .tx_vld(tx_vld), .audio_v1_bit(audio_v1_bit),
      .audio_v2_bit(audio_v2_bit), .mc_tx_bit(mc_tx_bit), .mc_rx_bit(mc_rx_bit),
      .esc_din(esc_din), .esc_dout(esc_dout), .esc_sclk(esc_sclk), .aux_din(aux_din),
      .aux_dout(aux_dout), .aux_sclk(aux_sclk), .aux_octet(aux_octet), .aux_lr_din(aux_lr_din),
      .ba_ext_in(ba_ext_in), .rx_fault(rx_fault), .ba_tx(ba_tx));
   esaom_term_model esaom_term_model_i (.link_clk(link_clk), .sync_lvl(sync_lvl),
      .aux_lvl(aux_lvl), .lr_lvl(lr_lvl), .esc_din(esc_din), .aux_din(aux_din),
      .aux_lr_din(aux_lr_din));

   always #2 hclk = ~hclk;
   // odd offset keeps the two clocks out of phase
   initial begin
      link_clk = 1'b0;
      #13;
      forever #32 link_clk = ~link_clk;
   end
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 60000) begin
         fails++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
      `CHK("hresp", 1'b0, hresp)
   endtask

   task automatic cfg(input esaom_pkg::esaom_ctrl_t cw);
      bus(1'b1, esaom_pkg::ADDR_CTRL, 32'(cw));
      repeat (6) @(posedge link_clk);
   endtask

   task automatic lkx(input esaom_pkg::esaom_kind_t k, input esaom_pkg::esaom_oslot_t s,
      input logic [2:0] b, input logic rx, input logic etx, input logic ees, input logic eax);
      @(posedge link_clk);
      lk_i <= '{stb: 1'b1, kind: k, slot: s, bitn: b};
      lk_rx_bit <= rx;
      @(posedge link_clk);
      lk_i.stb <= 1'b0;
      #1;
      `CHK("tx_vld", 1'b1, tx_vld)
      `CHK("tx_bit", etx, tx_bit)
      `CHK("esc_sclk", ees, esc_sclk)
      `CHK("aux_sclk", eax, aux_sclk)
   endtask

   // nine line bits per character: start, then data lsb first
   task automatic drain(input logic [7:0] ch);
      for (int i = 0; i < 9; i++) begin
         lkx(esaom_pkg::KIND_ESC8K, esaom_pkg::OSLOT_OTHER, 3'h0, 1'b1,
            (i == 0) ? 1'b0 : ch[i-1], 1'b0, 1'b0);
      end
   endtask

   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      lk_i = '0;
      {lk_rx_bit, audio_v1_bit, audio_v2_bit, mc_tx_bit, sync_lvl, lr_lvl} = 6'h3f;
      {aux_lvl, rx_fault} = 2'b00;
      ba_ext_in = 4'h0;
      repeat (5) @(posedge link_clk);
      @(posedge hclk) hresetn <= 1'b1;
      bus(1'b0, esaom_pkg::ADDR_CTRL, 32'h0000_0000);
      `CHK("ctrl_rst", 32'(esaom_pkg::CTRL_RST), rd)
      bus(1'b0, esaom_pkg::ADDR_BAUD, 32'h0000_0000);
      `CHK("baud_rst", 32'(esaom_pkg::BAUD_RST), rd)
      bus(1'b0, 8'h0c, 32'h0000_0000);
      `CHK("unmapped", 32'h0000_0000, rd)
      `CHK("tx_rst", 1'b1, tx_bit)
      `CHK("ba_rst", 4'h0, ba_tx)
      c = esaom_pkg::CTRL_RST;
      for (int i = 0; i < 4; i++) begin
         c.iaux = esaom_pkg::esaom_iaux_t'(i);
         cfg(c);
         v1a = (i == 1 || i == 2);
         v2a = (i == 1 || i == 3);
         lkx(esaom_pkg::KIND_ESC8K, esaom_pkg::OSLOT_OTHER, 3'h0, 1'b1, 1'b1, 1'b0, 1'b0);
         lkx(esaom_pkg::KIND_V1, esaom_pkg::OSLOT_OTHER, 3'h0, 1'b1, !v1a, 1'b0, v1a);
         lkx(esaom_pkg::KIND_V2, esaom_pkg::OSLOT_OTHER, 3'h0, 1'b1, !v2a, 1'b0, v2a);
      end
      c = esaom_pkg::CTRL_RST;
      c.service_overhead_channel = esaom_pkg::ESC_SYNC;
      cfg(c);
      sync_lvl <= 1'b0;
      repeat (4) @(posedge link_clk);
      lkx(esaom_pkg::KIND_ESC8K, esaom_pkg::OSLOT_OTHER, 3'h0, 1'b0, 1'b0, 1'b1, 1'b0);
      `CHK("esc_dout", 1'b0, esc_dout)
      // ibs off, low rate, sync aux, then closed net with service
      for (int m = 0; m < 4; m++) begin
         c.frm = (m == 3) ? esaom_pkg::FRM_CNS : esaom_pkg::FRM_IBS;
         c.baux = (m == 3) ? esaom_pkg::BAUX_OFF : esaom_pkg::esaom_baux_t'(m);
         cfg(c);
         for (int j = 0; j < 7; j++) begin
            s32b1 = (sl[j] == 2'd1) && (bn[j] == esaom_pkg::OVERHEAD_SLOT_THIRTYTWO_B1);
            sstd = (sl[j] == 2'd0) || (sl[j] == 2'd2) || (sl[j] == 2'd1 && bn[j] >= 3'd4);
            o = (m == 3) ? 1 : (m == 2) ? ((sstd || s32b1) ? 2 : 0)
               : (m == 1 && s32b1) ? 2 : sstd ? 1 : 0;
            lkx(esaom_pkg::KIND_OVH, esaom_pkg::esaom_oslot_t'(sl[j]), bn[j], o != 2,
               (o == 0) || (o == 2 && m == 1), o == 1, o == 2);
         end
      end
      // aux slots carried a received zero, every other slot a one
      `CHK("aux_dout", 1'b0, aux_dout)
      c = esaom_pkg::CTRL_RST;
      c.service_overhead_channel = esaom_pkg::ESC_SYNC;
      c.route_mc = 1'b1;
      cfg(c);
      sync_lvl <= 1'b1;
      mc_tx_bit <= 1'b0;
      repeat (4) @(posedge link_clk);
      lkx(esaom_pkg::KIND_ESC8K, esaom_pkg::OSLOT_OTHER, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      `CHK("mc_rx_bit", 1'b0, mc_rx_bit)
      c.route_mc = 1'b0;
      c.service_overhead_channel = esaom_pkg::ESC_ASYNC;
      cfg(c);
      bus(1'b1, esaom_pkg::ADDR_BAUD, 32'h0000_0003);
      repeat (6) @(posedge link_clk);
      esaom_term_model_i.send_char(8'ha5, 4);
      repeat (12) @(posedge link_clk);
      drain(8'ha5);
      lkx(esaom_pkg::KIND_ESC8K, esaom_pkg::OSLOT_OTHER, 3'h0, 1'b1, 1'b1, 1'b0, 1'b0);
      esaom_term_model_i.send_char(8'h3c, 4);
      esaom_term_model_i.send_char(8'hc3, 4);
      repeat (12) @(posedge link_clk);
      bus(1'b0, esaom_pkg::ADDR_STAT, 32'h0000_0000);
      `CHK("char_lost", 1'b1, rd[esaom_pkg::STAT_LOST])
      drain(8'h3c);
      bus(1'b1, esaom_pkg::ADDR_STAT, 32'h0000_0001);
      bus(1'b0, esaom_pkg::ADDR_STAT, 32'h0000_0000);
      `CHK("lost_clr", 1'b0, rd[esaom_pkg::STAT_LOST])
      c.ba_sel = 4'b0011;
      cfg(c);
      @(posedge hclk);
      ba_ext_in <= 4'b0101;
      rx_fault <= 1'b1;
      repeat (8) @(posedge hclk);
      `CHK("ba_tx", 4'b0111, ba_tx)
      bus(1'b0, esaom_pkg::ADDR_STAT, 32'h0000_0000);
      `CHK("ba_stat", 4'b0111, rd[4:1])
      rx_fault <= 1'b0;
      repeat (8) @(posedge hclk);
      `CHK("ba_tx", 4'b0100, ba_tx)
      tally_and_finish();
   end
endmodule // esc_aux_overhead_mux_bench
`undef CHK
`default_nettype wire
